// [common/rcd_pkg.sv]
// rcd_pkg: constants shared by the reset configuration word decoder.
// assumes word bit n of the documented numbering sits at vector bit 31-n.
package rcd_pkg;

  // *********************************************************************
  // configuration word field positions (vector bit = 31 - word bit)
  // *********************************************************************
  localparam int unsigned POS_ETHERNET_LOCATION = 12;
  localparam int unsigned POS_TRANSFER_TYPE_CFG = 11;
  localparam int unsigned POS_CHIP_SEL_FIVE_CFG = 10;
  localparam int unsigned POS_TRANSFER_CODE_HI  = 9;
  localparam int unsigned POS_TRANSFER_CODE_LO  = 8;
  localparam int unsigned POS_LITTLE_ENDIAN     = 7;
  localparam int unsigned POS_MUNGED_ENDIAN     = 6;
  localparam int unsigned POS_RESERVED_ZERO_A   = 5;
  localparam int unsigned POS_RESERVED_ONE      = 4;
  localparam int unsigned POS_CLOCK_MODE_HI     = 3;
  localparam int unsigned POS_CLOCK_MODE_LO     = 1;
  localparam int unsigned POS_RESERVED_ZERO_B   = 0;

  // *********************************************************************
  // system interface configuration register layout
  // *********************************************************************
  localparam int unsigned POS_CLOCK_OUT_DISABLE = 16;

  // *********************************************************************
  // reset values and encodings
  // *********************************************************************
  localparam logic [31:0] DEFAULT_CONFIG_WORD = 32'h0000_0000;
  localparam logic [1:0]  TCODE_TRANSFER_CODE = 2'h0;
  localparam logic [1:0]  TCODE_BANK_SELECT   = 2'h2;
  localparam logic [1:0]  SRC_DEFAULT_WORD    = 2'h1;

  // *********************************************************************
  // timing: word must arrive within this many reference clock cycles
  // *********************************************************************
  localparam int unsigned WORD_TIMEOUT_REF_CYCLES = 1024;
  localparam int unsigned REF_CLOCK_KHZ           = 10000;
  localparam int unsigned SYS_CLOCK_KHZ           = 10000;
  localparam int unsigned WORD_TIMEOUT_CYCLES     =
    (WORD_TIMEOUT_REF_CYCLES * SYS_CLOCK_KHZ) / REF_CLOCK_KHZ;

  typedef enum logic [1:0] {
    ST_SAMPLE,
    ST_WAIT_WORD,
    ST_HOLD,
    ST_RUN
  } rcd_state_t;

endpackage

// [src/rcd_sync.sv]
// rcd_sync: two-flop synchroniser for a group of level inputs.
// assumes each bit is a quasi-static level from outside the clock domain.
`timescale 1ns/1ps
module rcd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one_reg;
  logic [WIDTH-1:0] stage_two_reg;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage_one_reg <= '0;
      stage_two_reg <= '0;
    end else begin
      stage_one_reg <= async_in;
      stage_two_reg <= stage_one_reg;
    end
  end

  assign sync_out = stage_two_reg;

endmodule

// [src/rcd_decode.sv]
// rcd_decode: captures the hard reset configuration word and decodes its
// upper fields into pin-function selects, endian mode and clock mode.
// assumes straps, hard reset and word strobe come from pins (synchronised
// here) and that the source holds the word steady while its strobe is high.
//
// Functional notes
// - ethernet location bit picks host bus (if width strap low) or gpio
// - transfer type bit picks type lines or selects
// - chip select five bit picks select or buffer
// - transfer code field picks code or bank lines
// - endian bit picks big or little endian host
// - munged bit matters only in little endian
// - word supplies high clock mode bits
// - clock output disable masks bus clock
// - no word within 1024 cycles gives default
// - default straps take all-zero word
`timescale 1ns/1ps
module rcd_decode #(
  parameter int unsigned TIMEOUT_CYCLES = rcd_pkg::WORD_TIMEOUT_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        hard_reset_n_in,
  input  wire logic        host_port_width_strap_in,
  input  wire logic [1:0]  config_source_strap_in,
  input  wire logic [1:0]  clock_mode_strap_in,
  input  wire logic        config_word_valid_in,
  input  wire logic [31:0] config_word_in,
  input  wire logic        sys_cfg_wr_in,
  input  wire logic [31:0] sys_cfg_wdata_in,
  output logic      [31:0] sys_cfg_rdata_out,
  output logic      [31:0] hard_reset_config_word_out,
  output logic             config_ready_out,
  output logic             config_timeout_out,
  output logic             reserved_bits_bad_out,
  output logic             ethernet_on_host_bus_out,
  output logic             ethernet_on_gpio_out,
  output logic             transfer_type_lines_en_out,
  output logic             chip_select_5to7_en_out,
  output logic             chip_select_five_line_en_out,
  output logic             buffer_control_line_one_en_out,
  output logic             transfer_code_lines_en_out,
  output logic             bank_select_lines_en_out,
  output logic             little_endian_host_out,
  output logic             munged_endian_select_out,
  output logic      [4:0]  clock_mode_bits_out,
  output logic             bus_clk_out
);

  // *********************************************************************
  // synchronised pin inputs
  // *********************************************************************
  logic [6:0] pins_sync;
  logic       hreset_active;
  logic       width_strap_s;
  logic [1:0] source_strap_s;
  logic [1:0] mode_strap_s;
  logic       word_valid_s;

  rcd_sync #(
    .WIDTH (7)
  ) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .async_in   ({~hard_reset_n_in, host_port_width_strap_in, config_source_strap_in,
                  clock_mode_strap_in, config_word_valid_in}),
    .sync_out   (pins_sync)
  );

  assign hreset_active  = pins_sync[6];
  assign width_strap_s  = pins_sync[5];
  assign source_strap_s = pins_sync[4:3];
  assign mode_strap_s   = pins_sync[2:1];
  assign word_valid_s   = pins_sync[0];

  // *********************************************************************
  // state
  // *********************************************************************
  typedef struct packed {
    rcd_pkg::rcd_state_t st;
    logic [12:0]         cnt;
    logic                valid_prev;
    logic [31:0]         word;
    logic                width_strap;
    logic [1:0]          mode_lo;
    logic                timeout;
    logic                transfer_type_pin_cfg;
    logic                chip_select_five_pin_cfg;
    logic [1:0]          transfer_code_pin_cfg;
    logic                clock_output_disable;
    logic                clk_div;
    logic                ready;
  } rcd_regs_t;

  rcd_regs_t state_reg;
  rcd_regs_t state_next;

  always_comb begin
    state_next            = state_reg;
    state_next.valid_prev = word_valid_s;
    if (hreset_active) begin
      state_next.st    = rcd_pkg::ST_SAMPLE;
      state_next.ready = 1'b0;
      state_next.cnt   = '0;
    end else begin
      unique case (state_reg.st)
        rcd_pkg::ST_SAMPLE: begin
          // no word yet, wait for reset
          state_next.st = rcd_pkg::ST_SAMPLE;
        end
        rcd_pkg::ST_WAIT_WORD: begin
          state_next.word    = rcd_pkg::DEFAULT_CONFIG_WORD;
          state_next.timeout = 1'b1;
          state_next.st      = rcd_pkg::ST_HOLD;
        end
        rcd_pkg::ST_HOLD: begin
          // hand decoded fields over at release
          state_next.transfer_type_pin_cfg  = state_reg.word[rcd_pkg::POS_TRANSFER_TYPE_CFG];
          state_next.chip_select_five_pin_cfg = state_reg.word[rcd_pkg::POS_CHIP_SEL_FIVE_CFG];
          state_next.transfer_code_pin_cfg  = state_reg.word[rcd_pkg::POS_TRANSFER_CODE_HI:rcd_pkg::POS_TRANSFER_CODE_LO];
          state_next.clock_output_disable = 1'b0;
          state_next.ready = 1'b1;
          state_next.st    = rcd_pkg::ST_RUN;
        end
        rcd_pkg::ST_RUN: begin
          if (sys_cfg_wr_in) begin
            state_next.transfer_type_pin_cfg  = sys_cfg_wdata_in[rcd_pkg::POS_TRANSFER_TYPE_CFG];
            state_next.chip_select_five_pin_cfg = sys_cfg_wdata_in[rcd_pkg::POS_CHIP_SEL_FIVE_CFG];
            state_next.transfer_code_pin_cfg  = sys_cfg_wdata_in[rcd_pkg::POS_TRANSFER_CODE_HI:rcd_pkg::POS_TRANSFER_CODE_LO];
            state_next.clock_output_disable = sys_cfg_wdata_in[rcd_pkg::POS_CLOCK_OUT_DISABLE];
          end
        end
      endcase
    end
    if (hreset_active) begin
      unique case (state_reg.st)
        rcd_pkg::ST_SAMPLE: begin
          state_next.width_strap = width_strap_s;
          state_next.mode_lo     = mode_strap_s;
          state_next.timeout     = 1'b0;
          if (source_strap_s == rcd_pkg::SRC_DEFAULT_WORD) begin
            state_next.word = rcd_pkg::DEFAULT_CONFIG_WORD;
            state_next.st   = rcd_pkg::ST_HOLD;
          end else begin
            state_next.st = rcd_pkg::ST_WAIT_WORD;
          end
        end
        rcd_pkg::ST_WAIT_WORD: begin
          state_next.cnt = state_reg.cnt + 13'h0001;
          if (word_valid_s && !state_reg.valid_prev) begin
            state_next.word = config_word_in;
            state_next.st   = rcd_pkg::ST_HOLD;
          end else if (state_reg.cnt == 13'(TIMEOUT_CYCLES - 1)) begin
            state_next.word    = rcd_pkg::DEFAULT_CONFIG_WORD;
            state_next.timeout = 1'b1;
            state_next.st      = rcd_pkg::ST_HOLD;
          end else begin
            state_next.st = rcd_pkg::ST_WAIT_WORD;
          end
        end
        rcd_pkg::ST_HOLD: begin
          state_next.st = rcd_pkg::ST_HOLD;
        end
        rcd_pkg::ST_RUN: begin
          state_next.st = rcd_pkg::ST_SAMPLE;
        end
      endcase
    end
    // masked clock holds low from the write on
    state_next.clk_div = state_next.clock_output_disable ? 1'b0 : ~state_reg.clk_div;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '{st: rcd_pkg::ST_SAMPLE, cnt: 13'h0000, valid_prev: 1'b0,
                     word: rcd_pkg::DEFAULT_CONFIG_WORD, width_strap: 1'b0,
                     mode_lo: 2'h0, timeout: 1'b0, transfer_type_pin_cfg: 1'b0, chip_select_five_pin_cfg: 1'b0,
                     transfer_code_pin_cfg: 2'h0, clock_output_disable: 1'b0, clk_div: 1'b0, ready: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // *********************************************************************
  // decoded outputs
  // *********************************************************************
  logic ethernet_location_select;
  logic little_endian_host;

  assign ethernet_location_select = state_reg.word[rcd_pkg::POS_ETHERNET_LOCATION];
  assign little_endian_host = state_reg.word[rcd_pkg::POS_LITTLE_ENDIAN];

  assign hard_reset_config_word_out = state_reg.word;
  assign config_ready_out           = state_reg.ready;
  assign config_timeout_out         = state_reg.timeout;

  // flag reserved zero bits driven high
  // flag reserved one bit driven low
  assign reserved_bits_bad_out = state_reg.ready &
                                 (state_reg.word[rcd_pkg::POS_RESERVED_ZERO_A] |
                                  state_reg.word[rcd_pkg::POS_RESERVED_ZERO_B] |
                                  ~state_reg.word[rcd_pkg::POS_RESERVED_ONE]);

  assign ethernet_on_host_bus_out = ethernet_location_select & ~state_reg.width_strap;
  assign ethernet_on_gpio_out     = ~ethernet_location_select;

  assign transfer_type_lines_en_out = ~state_reg.transfer_type_pin_cfg;
  assign chip_select_5to7_en_out    = state_reg.transfer_type_pin_cfg;

  assign chip_select_five_line_en_out   = ~state_reg.chip_select_five_pin_cfg;
  assign buffer_control_line_one_en_out = state_reg.chip_select_five_pin_cfg;

  assign transfer_code_lines_en_out = (state_reg.transfer_code_pin_cfg == rcd_pkg::TCODE_TRANSFER_CODE);
  assign bank_select_lines_en_out   = (state_reg.transfer_code_pin_cfg == rcd_pkg::TCODE_BANK_SELECT);

  assign little_endian_host_out = little_endian_host;

  assign munged_endian_select_out = little_endian_host & state_reg.word[rcd_pkg::POS_MUNGED_ENDIAN];

  // high word bits above strap bits
  assign clock_mode_bits_out = {state_reg.word[rcd_pkg::POS_CLOCK_MODE_HI:rcd_pkg::POS_CLOCK_MODE_LO],
                                state_reg.mode_lo};

  // bus clock masked by disable bit
  assign bus_clk_out = state_reg.clk_div;

  always_comb begin
    sys_cfg_rdata_out                                    = 32'h0000_0000;
    sys_cfg_rdata_out[rcd_pkg::POS_TRANSFER_TYPE_CFG]    = state_reg.transfer_type_pin_cfg;
    sys_cfg_rdata_out[rcd_pkg::POS_CHIP_SEL_FIVE_CFG]    = state_reg.chip_select_five_pin_cfg;
    sys_cfg_rdata_out[rcd_pkg::POS_TRANSFER_CODE_HI]     = state_reg.transfer_code_pin_cfg[1];
    sys_cfg_rdata_out[rcd_pkg::POS_TRANSFER_CODE_LO]     = state_reg.transfer_code_pin_cfg[0];
    sys_cfg_rdata_out[rcd_pkg::POS_CLOCK_OUT_DISABLE]    = state_reg.clock_output_disable;
  end

endmodule

// [verif/rcd_sva.sv]
// rcd_sva: port checker for the configuration word decoder.
// assumes it is bound into rcd_decode and sees only its ports.
`timescale 1ns/1ps
module rcd_sva (
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  input wire logic        hard_reset_n_in,
  input wire logic [31:0] sys_cfg_rdata_out,
  input wire logic [31:0] hard_reset_config_word_out,
  input wire logic        config_ready_out,
  input wire logic        config_timeout_out,
  input wire logic        ethernet_on_host_bus_out,
  input wire logic        ethernet_on_gpio_out,
  input wire logic        transfer_type_lines_en_out,
  input wire logic        buffer_control_line_one_en_out,
  input wire logic        bank_select_lines_en_out,
  input wire logic        little_endian_host_out,
  input wire logic        munged_endian_select_out,
  input wire logic [4:0]  clock_mode_bits_out,
  input wire logic        bus_clk_out
);
  // ***************************************************************
  // properties
  // ***************************************************************
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_release;
    $rose(hard_reset_n_in);
  endsequence
  sequence s_loaded;
    ##[1:6] config_ready_out;
  endsequence
  a_ready_after_release: assert property (s_release |-> s_loaded)
    else $error("ready missing after hard reset release");
  a_word_held: assert property (config_ready_out && $past(config_ready_out) |-> $stable(hard_reset_config_word_out))
    else $error("word changed while ready");
  a_eth_gpio: assert property (ethernet_on_gpio_out == !hard_reset_config_word_out[12])
    else $error("gpio ethernet select wrong");
  a_eth_host: assert property (ethernet_on_host_bus_out |-> hard_reset_config_word_out[12])
    else $error("host ethernet select without word bit");
  a_type_sel: assert property (transfer_type_lines_en_out == !sys_cfg_rdata_out[11])
    else $error("transfer type select wrong");
  a_buffer_sel: assert property (buffer_control_line_one_en_out == sys_cfg_rdata_out[10])
    else $error("buffer control select wrong");
  a_bank_sel: assert property (bank_select_lines_en_out == (sys_cfg_rdata_out[9:8] == 2'h2))
    else $error("bank select wrong");
  a_endian_map: assert property ({little_endian_host_out, munged_endian_select_out} ==
    {hard_reset_config_word_out[7], hard_reset_config_word_out[7] & hard_reset_config_word_out[6]})
    else $error("endian outputs wrong");
  a_clock_mode_hi: assert property (clock_mode_bits_out[4:2] == hard_reset_config_word_out[3:1])
    else $error("clock mode high bits wrong");
  a_clk_masked: assert property (sys_cfg_rdata_out[16] |-> !bus_clk_out)
    else $error("bus clock not masked");
  a_timeout_zero: assert property (config_timeout_out |-> hard_reset_config_word_out == 32'h0)
    else $error("timeout without default word");
endmodule
bind rcd_decode rcd_sva rcd_sva_inst (.*);

// [verif/rcd_word_source.sv]
// rcd_word_source: boot source that presents the configuration word.
// assumes the bench calls send during hard reset, and once after release for the late strobe test.
`timescale 1ns/1ps
module rcd_word_source (
  input  wire logic        clk_sys_in,
  output logic             valid_out,
  output logic [31:0]      word_out
);
  initial begin
    valid_out = 1'b0;
    word_out = 32'h0;
  end
  task automatic send(input logic [31:0] w, input bit bad, input int gap);
    repeat (gap) @(posedge clk_sys_in);
    #10;
    word_out = bad ? w : (w & ~32'h0000_0021) | 32'h0000_0010;
    valid_out = 1'b1;
    repeat (4) @(posedge clk_sys_in);
    #10 valid_out = 1'b0;
    // released bus shows the inverse
    word_out = ~word_out;
  endtask
endmodule

// [verif/testbench.sv]
// testbench: random and corner configuration words through hard resets.
// assumes rcd_word_source as the boot source and a shortened timeout.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
  localparam int unsigned TMO = 32;
  logic        clk_sys_in, reset_n_in, hard_reset_n_in, host_port_width_strap_in, b;
  logic        config_word_valid_in, sys_cfg_wr_in, config_ready_out, config_timeout_out;
  logic [1:0]  config_source_strap_in, clock_mode_strap_in;
  logic [31:0] config_word_in, sys_cfg_wdata_in, sys_cfg_rdata_out, hard_reset_config_word_out, w;
  logic        reserved_bits_bad_out, ethernet_on_host_bus_out, ethernet_on_gpio_out;
  logic        transfer_type_lines_en_out, chip_select_5to7_en_out, chip_select_five_line_en_out;
  logic        buffer_control_line_one_en_out, transfer_code_lines_en_out, bank_select_lines_en_out;
  logic        little_endian_host_out, munged_endian_select_out, bus_clk_out;
  logic [4:0]  clock_mode_bits_out;
  int          n_fail, num_checks;
  rcd_decode #(.TIMEOUT_CYCLES(TMO)) rcd_decode_inst (.*);
  rcd_word_source rcd_word_source_inst (.clk_sys_in, .valid_out(config_word_valid_in), .word_out(config_word_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hard_cycle(input logic [1:0] s, input logic [31:0] wd, input bit send, input bit bad);
    @(posedge clk_sys_in);
    #10;
    config_source_strap_in = s;
    clock_mode_strap_in = 2'($urandom);
    host_port_width_strap_in = 1'($urandom);
    hard_reset_n_in = 1'b0;
    repeat (5) @(posedge clk_sys_in);
    if (send) rcd_word_source_inst.send(wd, bad, $urandom_range(0, 3));
    else repeat (TMO + 10) @(posedge clk_sys_in);
    #10 hard_reset_n_in = 1'b1;
    for (int i = 0; i < 20 && config_ready_out !== 1'b1; i++) @(posedge clk_sys_in);
    #10;
  endtask
  task automatic check_fields(input logic [31:0] x);
    `CHK("word", x, hard_reset_config_word_out)
    `CHK("eth", {x[12] & ~host_port_width_strap_in, ~x[12]}, {ethernet_on_host_bus_out, ethernet_on_gpio_out})
    `CHK("ttype", {~x[11], x[11]}, {transfer_type_lines_en_out, chip_select_5to7_en_out})
    `CHK("cs5", {~x[10], x[10]}, {chip_select_five_line_en_out, buffer_control_line_one_en_out})
    `CHK("tcode", {x[9:8] == 2'h0, x[9:8] == 2'h2}, {transfer_code_lines_en_out, bank_select_lines_en_out})
    `CHK("endian", {x[7], x[7] & x[6]}, {little_endian_host_out, munged_endian_select_out})
    `CHK("clkmode", {x[3:1], clock_mode_strap_in}, clock_mode_bits_out)
    `CHK("resv", x[5] | x[0] | ~x[4], reserved_bits_bad_out)
    `CHK("rdata0", x & 32'h0000_0f00, sys_cfg_rdata_out)
  endtask
  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    // hard reset pin idles high so the first strap sample sees the bench straps
    {reset_n_in, hard_reset_n_in, host_port_width_strap_in, sys_cfg_wr_in} = 4'h4;
    {config_source_strap_in, clock_mode_strap_in, sys_cfg_wdata_in} = 36'h0;
    w = $urandom(32'h7036);
    repeat (12) @(posedge clk_sys_in);
    #10 reset_n_in = 1'b1;
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 32'h0000_1fde : (i == 1) ? 32'h0000_0110 : (i == 2) ? 32'h0000_0290 : $urandom;
      hard_cycle(2'h0, w, 1'b1, 1'b0);
      check_fields((w & ~32'h0000_0021) | 32'h0000_0010);
      `CHK("timeout", 1'b0, config_timeout_out)
    end
    $display("test word decode done");
    w = $urandom | 32'h0000_0021;
    hard_cycle(2'h0, w, 1'b1, 1'b1);
    check_fields(w);
    $display("test reserved bits done");
    hard_cycle(rcd_pkg::SRC_DEFAULT_WORD, 32'hffff_ffff, 1'b1, 1'b1);
    check_fields(rcd_pkg::DEFAULT_CONFIG_WORD);
    $display("test default straps done");
    hard_cycle(2'h0, 32'h0, 1'b0, 1'b0);
    check_fields(rcd_pkg::DEFAULT_CONFIG_WORD);
    `CHK("timeout", 1'b1, config_timeout_out)
    $display("test no word done");
    rcd_word_source_inst.send(32'h0000_1ffe, 1'b0, 0);
    repeat (4) @(posedge clk_sys_in);
    check_fields(rcd_pkg::DEFAULT_CONFIG_WORD);
    $display("test late strobe done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys_in);
      #10 sys_cfg_wr_in = 1'b1;
      sys_cfg_wdata_in = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
      @(posedge clk_sys_in);
      #10 sys_cfg_wr_in = 1'b0;
      w = sys_cfg_wdata_in & 32'h0001_0f00;
      `CHK("rdata", w, sys_cfg_rdata_out)
      `CHK("sel", {~w[11], w[10], w[9:8] == 2'h2}, {transfer_type_lines_en_out,
        buffer_control_line_one_en_out, bank_select_lines_en_out})
      b = bus_clk_out;
      @(posedge clk_sys_in);
      #10;
      `CHK("busclk", w[16] ? 1'b0 : ~b, bus_clk_out)
    end
    $display("test register writes done");
    report_and_stop;
  end
  initial begin
    #1_000_000;
    n_fail++;
    report_and_stop;
  end
endmodule
